/* rtl/pcb_bank.sv */
// performance counter bank: clear-on-read counters and one-second sums
//
// Contract
// RULE1 - count received valid cells, 16 bits, high/low bytes, since last read
// RULE2 - count discarded cells, 16 bits over two bytes, since last read
// RULE3 - count transmitted idle cells, 16 bits over two bytes
// RULE4 - count transmitted valid cells, 16 bits over two bytes
// RULE5 - atm mode: shared counter counts received idle cells, low byte second
// RULE6 - clear-channel mode: shared counter counts prbs bit errors instead
// RULE7 - cell counters and hec accumulation only work in atm mode
// RULE8 - counter bytes return value on read then restart; zero after reset
// RULE9 - on narrow bus, reading one byte loads companion into hold register
// RULE10 - errored-second bit set when any error in last second
// RULE11 - severe bit set when error rate exceeded one in ten thousand
// RULE12 - read-only pair shows last second's line code violations
// RULE13 - read-only pair shows last second's p-bit errors
// RULE14 - read-only pair shows last second's hec errors
// RULE15 - accumulators are not cleared by reads, hold last complete second
// RULE16 - reading either byte snapshots both and clears live counter once
// RULE17 - at second boundary move totals, update status, restart totals
`timescale 1ns/1ps
module pcb_bank (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // mode straps from channel configuration
  input wire logic atm_mode,
  // host register port
  input wire pcb_pkg::pcb_req_s req,
  output logic [15:0] rdata,
  output logic rvalid,
  // events, one-cycle pulses on sys_clk
  input wire pcb_pkg::pcb_evt_s evt,
  // payload bits counted this cycle, for the severe-error rate
  input wire logic bit_tick
);
  import pcb_pkg::*;

  typedef struct packed {
    logic [15:0] rdata;
    logic rvalid;
    logic [7:0] hold;
    logic [15:0] lcv_run;
    logic [15:0] pbit_run;
    logic [15:0] hec_run;
    logic [31:0] bits_run;
    logic [15:0] lcv_acc;
    logic [15:0] pbit_acc;
    logic [15:0] hec_acc;
    logic es;
    logic ses;
    logic [2:0] last_ci;
    logic last_hi;
    logic last_valid;
  } pcb_state_s;

  pcb_state_s st_reg;
  pcb_state_s st_next;
  // kept out of the state struct: it runs on the raw reset
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [NCNT-1:0] inc;
  logic [NCNT-1:0] snap;
  logic [15:0] cval [NCNT];
  logic [15:0] live_view [NCNT];

  // saturating add of one pulse
  function automatic logic [15:0] sat_inc(input logic [15:0] v,
                                          input logic e);
    sat_inc = (e && v != 16'hffff) ? v + 16'h0001 : v;
  endfunction

  // map a counter offset to its index; returns valid flag in bit 3
  function automatic logic [3:0] cnt_idx(input logic [7:0] a);
    case (a)
      OFS_RX_IDLE_HI, OFS_RX_IDLE_LO: cnt_idx = {1'b1, CI_RX_IDLE};
      OFS_RX_VALID_HI, OFS_RX_VALID_LO: cnt_idx = {1'b1, CI_RX_VALID};
      OFS_DROPPED_HI, OFS_DROPPED_LO: cnt_idx = {1'b1, CI_DROPPED};
      OFS_TX_IDLE_HI, OFS_TX_IDLE_LO: cnt_idx = {1'b1, CI_TX_IDLE};
      OFS_TX_VALID_HI, OFS_TX_VALID_LO: cnt_idx = {1'b1, CI_TX_VALID};
      default: cnt_idx = 4'h0;
    endcase
  endfunction

  // reset release through two flops; only the second one is used
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // event selection per counter
  always_comb begin
    inc[CI_RX_IDLE] = atm_mode ? evt.rx_idle : evt.prbs_err; // RULE5 RULE6
    inc[CI_RX_VALID] = atm_mode & evt.rx_valid; // RULE1 RULE7
    inc[CI_DROPPED] = atm_mode & evt.dropped; // RULE2 RULE7
    inc[CI_TX_IDLE] = atm_mode & evt.tx_idle; // RULE3 RULE7
    inc[CI_TX_VALID] = atm_mode & evt.tx_valid; // RULE4 RULE7
  end

  // a read of either byte snapshots that counter once
  wire logic rd_acc = req.cs & req.rd;
  wire logic [3:0] ridx = cnt_idx(req.addr);
  // even offsets carry the high byte, counters and accumulators alike
  wire logic is_hi = ~req.addr[0];
  always_comb begin
    for (int i = 0; i < NCNT; i++) begin
      // other byte of a pair, read next on a narrow bus, reuses the earlier snapshot;
      // the same byte read again starts a new interval
      snap[i] = rd_acc && ridx[3] && ridx[2:0] == 3'(i) &&
        (req.wide || !(st_reg.last_valid && st_reg.last_ci == 3'(i) &&
        st_reg.last_hi != is_hi));
    end
  end // RULE16 RULE8

  // the five clear-on-read counters
  genvar g;
  generate
    for (g = 0; g < NCNT; g++) begin : gen_cnt
      pcb_counter u_cnt (
        .clk(sys_clk),
        .rst_n(rst_n),
        .inc(inc[g]),
        .snap(snap[g]),
        .snap_val(cval[g]),
        .live_val(live_view[g])
      );
    end
  endgenerate

  // register state: one-second sums, read data and companion hold
  always_comb begin
    logic [15:0] pair;
    logic pair_ok;
    logic sec_err;
    logic [31:0] limit;
    pair = CNT_RESET;
    pair_ok = 1'b0;
    sec_err = 1'b0;
    limit = 32'h0000_0000;
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    // running totals; hec counted only in atm mode
    st_next.lcv_run = sat_inc(st_reg.lcv_run, evt.line_code_violation);
    st_next.pbit_run = sat_inc(st_reg.pbit_run, evt.pbit);
    st_next.hec_run = sat_inc(st_reg.hec_run, evt.hec & atm_mode); // RULE7
    st_next.bits_run = st_reg.bits_run + {31'h0000_0000, bit_tick};
    if (evt.one_sec) begin
      // errors counted this second, including this cycle's pulses
      sec_err = (st_next.lcv_run | st_next.pbit_run |
                 st_next.hec_run) != 16'h0000;
      limit = st_next.bits_run / 32'(SES_RATIO);
      st_next.lcv_acc = st_next.lcv_run; // RULE12 RULE17
      st_next.pbit_acc = st_next.pbit_run; // RULE13 RULE17
      st_next.hec_acc = st_next.hec_run; // RULE14 RULE17
      st_next.es = sec_err; // RULE10
      st_next.ses = 32'(st_next.lcv_run) + 32'(st_next.pbit_run) >
                    limit; // RULE11
      st_next.lcv_run = CNT_RESET; // RULE17
      st_next.pbit_run = CNT_RESET;
      st_next.hec_run = CNT_RESET;
      st_next.bits_run = 32'h0000_0000;
    end
    if (rd_acc) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = CNT_RESET;
      case (req.addr)
        OFS_HOLD: st_next.rdata = {8'h00, st_reg.hold}; // RULE9
        OFS_SEC_STATUS: begin
          st_next.rdata = CNT_RESET;
          st_next.rdata[ES_BIT] = st_reg.es;
          st_next.rdata[SES_BIT] = st_reg.ses;
        end
        OFS_LCV_HI, OFS_LCV_LO: begin
          pair = st_reg.lcv_acc; // RULE15
          pair_ok = 1'b1;
        end
        OFS_PBIT_HI, OFS_PBIT_LO: begin
          pair = st_reg.pbit_acc; // RULE15
          pair_ok = 1'b1;
        end
        OFS_HEC_HI, OFS_HEC_LO: begin
          pair = st_reg.hec_acc; // RULE15
          pair_ok = 1'b1;
        end
        default: begin
          pair_ok = ridx[3];
        end
      endcase
      st_next.last_valid = 1'b0;
      if (pair_ok) begin
        if (ridx[3]) begin
          // snapshot taken this cycle, or the held one for companion
          pair = snap[ridx[2:0]] ? live_view[ridx[2:0]] :
            cval[ridx[2:0]];
          st_next.last_valid = snap[ridx[2:0]] & ~req.wide;
          st_next.last_ci = ridx[2:0];
          st_next.last_hi = is_hi;
        end
        if (req.wide) begin
          st_next.rdata = pair;
        end else begin
          st_next.rdata = {8'h00, is_hi ? pair[15:8] : pair[7:0]}; // RULE8
          st_next.hold = is_hi ? pair[7:0] : pair[15:8]; // RULE9
        end
      end
    end
  end

  // single state register; the reset synchroniser has its own process
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.rdata <= CNT_RESET;
      st_reg.rvalid <= 1'b0;
      st_reg.hold <= BYTE_RESET;
      st_reg.lcv_run <= CNT_RESET;
      st_reg.pbit_run <= CNT_RESET;
      st_reg.hec_run <= CNT_RESET;
      st_reg.bits_run <= 32'h0000_0000;
      st_reg.lcv_acc <= CNT_RESET;
      st_reg.pbit_acc <= CNT_RESET;
      st_reg.hec_acc <= CNT_RESET;
      st_reg.es <= 1'b0;
      st_reg.ses <= 1'b0;
      st_reg.last_ci <= 3'h0;
      st_reg.last_hi <= 1'b0;
      st_reg.last_valid <= 1'b0;
    end else begin
      st_reg.rdata <= st_next.rdata;
      st_reg.rvalid <= st_next.rvalid;
      st_reg.hold <= st_next.hold;
      st_reg.lcv_run <= st_next.lcv_run;
      st_reg.pbit_run <= st_next.pbit_run;
      st_reg.hec_run <= st_next.hec_run;
      st_reg.bits_run <= st_next.bits_run;
      st_reg.lcv_acc <= st_next.lcv_acc;
      st_reg.pbit_acc <= st_next.pbit_acc;
      st_reg.hec_acc <= st_next.hec_acc;
      st_reg.es <= st_next.es;
      st_reg.ses <= st_next.ses;
      st_reg.last_ci <= st_next.last_ci;
      st_reg.last_hi <= st_next.last_hi;
      st_reg.last_valid <= st_next.last_valid;
    end
  end

  // read answer, registered
  assign rdata = st_reg.rdata;
  assign rvalid = st_reg.rvalid;
endmodule

/* rtl/pcb_counter.sv */
// clear-on-read 16-bit event counter with a snapshot on read
`timescale 1ns/1ps
module pcb_counter (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic inc,
  input wire logic snap,
  // data
  output logic [15:0] snap_val,
  output logic [15:0] live_val
);
  import pcb_pkg::*;

  typedef struct packed {
    logic [15:0] live;
    logic [15:0] held;
  } pcb_cnt_s;

  pcb_cnt_s st_reg;
  pcb_cnt_s st_next;

  // snapshot and clear once; an increment in the same cycle is kept
  always_comb begin
    st_next = st_reg;
    if (snap) begin
      st_next.held = st_reg.live;
      st_next.live = inc ? 16'h0001 : CNT_RESET;
    end else if (inc && st_reg.live != 16'hffff) begin
      st_next.live = st_reg.live + 16'h0001;
    end
  end

  // saturate rather than wrap, so a lost read is visible
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign snap_val = st_reg.held;
  // live total, so a read can return it in the cycle of the snapshot
  assign live_val = st_reg.live;
endmodule

/* rtl/pcb_pkg.sv */
// package: register map, field layout and constants of the counter bank
package pcb_pkg;
  localparam logic [7:0] OFS_RX_IDLE_HI = 8'h32;
  localparam logic [7:0] OFS_RX_IDLE_LO = 8'h33;
  localparam logic [7:0] OFS_RX_VALID_HI = 8'h34;
  localparam logic [7:0] OFS_RX_VALID_LO = 8'h35;
  localparam logic [7:0] OFS_DROPPED_HI = 8'h36;
  localparam logic [7:0] OFS_DROPPED_LO = 8'h37;
  localparam logic [7:0] OFS_TX_IDLE_HI = 8'h38;
  localparam logic [7:0] OFS_TX_IDLE_LO = 8'h39;
  localparam logic [7:0] OFS_TX_VALID_HI = 8'h3a;
  localparam logic [7:0] OFS_TX_VALID_LO = 8'h3b;
  localparam logic [7:0] OFS_HOLD = 8'h3c;
  localparam logic [7:0] OFS_SEC_STATUS = 8'h3d;
  localparam logic [7:0] OFS_LCV_HI = 8'h3e;
  localparam logic [7:0] OFS_LCV_LO = 8'h3f;
  localparam logic [7:0] OFS_PBIT_HI = 8'h40;
  localparam logic [7:0] OFS_PBIT_LO = 8'h41;
  localparam logic [7:0] OFS_HEC_HI = 8'h42;
  localparam logic [7:0] OFS_HEC_LO = 8'h43;
  // status bit positions
  localparam int ES_BIT = 1;
  localparam int SES_BIT = 0;
  // reset values
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // severe threshold: errors above one in ten thousand bits
  localparam int SES_RATIO = 10000;
  // number of clear-on-read counters
  localparam int NCNT = 5;
  localparam logic [2:0] CI_RX_IDLE = 3'h0;
  localparam logic [2:0] CI_RX_VALID = 3'h1;
  localparam logic [2:0] CI_DROPPED = 3'h2;
  localparam logic [2:0] CI_TX_IDLE = 3'h3;
  localparam logic [2:0] CI_TX_VALID = 3'h4;

  typedef enum logic [0:0] {
    PCB_IDLE = 1'b0,
    PCB_DONE = 1'b1
  } pcb_bus_e;

  // host bus request
  typedef struct packed {
    logic cs;
    logic rd;
    logic [7:0] addr;
    logic wide;
  } pcb_req_s;

  // event pulses from the framer and cell processors
  typedef struct packed {
    logic rx_idle;
    logic prbs_err;
    logic rx_valid;
    logic dropped;
    logic tx_idle;
    logic tx_valid;
    logic line_code_violation;
    logic pbit;
    logic hec;
    logic one_sec;
  } pcb_evt_s;
endpackage

/* testbench/pcb_bank_checker.sv */
// checker: read timing, clear-on-read and accumulator checks of the bank
`timescale 1ns/1ps
module pcb_bank_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // mode, host and event side
  input wire logic atm_mode,
  input wire pcb_pkg::pcb_req_s req,
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  input wire pcb_pkg::pcb_evt_s evt,
  input wire logic bit_tick
);
  import pcb_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // decoded read kinds; wide reads give a whole counter per cycle
  logic rd_w, cnt_w, acc_w, map_w;
  assign rd_w = req.cs && req.rd;
  assign cnt_w = rd_w && req.wide && req.addr inside {[8'h32:8'h3b]};
  assign acc_w = rd_w && req.wide && req.addr inside {[8'h3e:8'h43]};
  assign map_w = req.addr inside {[8'h32:8'h43]};
  // same counter read twice with no events in between
  sequence cnt_twice;
    (cnt_w && evt == '0) ##1 (cnt_w && evt == '0 && $stable(req.addr));
  endsequence
  // same accumulator read twice with no second boundary
  sequence acc_twice;
    (acc_w && !evt.one_sec) ##1 (acc_w && !evt.one_sec && $stable(req.addr));
  endsequence
  resp_lat_a: assert property (rd_w |=> rvalid)
    else $error("read not answered next cycle");
  resp_once_a: assert property (!rd_w |=> !rvalid)
    else $error("answer without a read");
  narrow_top_a: assert property
    (rd_w && !req.wide |=> rdata[15:8] == 8'h00)
    else $error("narrow read drives upper byte");
  unmapped_a: assert property (rd_w && !map_w |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  status_pad_a: assert property
    (rd_w && req.addr == OFS_SEC_STATUS |=> rdata[15:2] == '0)
    else $error("status unused bits set");
  clr_read_a: assert property (cnt_twice |=> rdata == 16'h0000)
    else $error("counter not cleared by read");
  acc_keep_a: assert property (acc_twice |=> rdata == $past(rdata))
    else $error("accumulator changed by read");
  rdata_hold_a: assert property (!rd_w |=> $stable(rdata))
    else $error("read data moved without a read");
endmodule

bind pcb_bank pcb_bank_checker chk (.sys_clk(sys_clk), .nrst(nrst),
  .atm_mode(atm_mode), .req(req), .rdata(rdata), .rvalid(rvalid),
  .evt(evt), .bit_tick(bit_tick));

/* testbench/pcb_bank_tb.sv */
// testbench: register reads, cell counting and one-second sums of the bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  bad_count++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module pcb_bank_tb;
  import pcb_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic atm_mode = 1'b1;
  logic bit_tick = 1'b0;
  pcb_req_s req = '0;
  pcb_evt_s evt = '0;
  logic [15:0] rdata;
  logic rvalid;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [15:0] d1, d2, ex;
  pcb_bank uut (.sys_clk(sys_clk), .nrst(nrst), .atm_mode(atm_mode),
    .req(req), .rdata(rdata), .rvalid(rvalid), .evt(evt),
    .bit_tick(bit_tick));
  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;
  task give_verdict;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // hang guard: the run needs about 22000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      give_verdict();
    end
  end
  // one read; strobes held for exactly one taking edge
  task rd(input logic [7:0] a, input logic w, output logic [15:0] d);
    @(negedge sys_clk);
    req = '{cs: 1'b1, rd: 1'b1, addr: a, wide: w};
    @(negedge sys_clk);
    req = '0;
    `CHK("rvalid", 1'b1, rvalid)
    d = rdata;
  endtask
  // two back-to-back wide reads of one offset
  task rd2(input logic [7:0] a, output logic [15:0] f, output logic [15:0] s);
    @(negedge sys_clk);
    req = '{cs: 1'b1, rd: 1'b1, addr: a, wide: 1'b1};
    @(negedge sys_clk);
    f = rdata;
    @(negedge sys_clk);
    req = '0;
    s = rdata;
    `CHK("rvalid", 1'b1, rvalid)
  endtask
  // event lines held n cycles, one count per cycle
  task pulse(input pcb_evt_s m, input int n);
    @(negedge sys_clk);
    evt = m;
    repeat (n) @(negedge sys_clk);
    evt = '0;
  endtask
  // reset values, unmapped offsets on both sides read as zero
  task t_reset;
    for (int a = 8'h31; a <= 8'h44; a++) begin
      rd2(8'(a), d1, d2);
      `CHK("reset value", 16'h0000, d1)
    end
  endtask
  // every cell counter, counts past one byte, narrow and wide
  task t_cells;
    int bits [5];
    bits = '{9, 7, 6, 5, 4};
    for (int i = 0; i < NCNT; i++) begin
      pulse(pcb_evt_s'(10'h001 << bits[i]), 258 + 17 * i);
      ex = 16'(258 + 17 * i);
      if (i[0]) begin
        rd2(8'(8'h32 + 2 * i), d1, d2);
        `CHK("wide count", ex, d1)
        `CHK("after read", 16'h0000, d2)
      end else begin
        rd(8'(8'h32 + 2 * i), 1'b0, d1);
        `CHK("high byte", {8'h00, ex[15:8]}, d1)
        rd(OFS_HOLD, 1'b0, d1);
        `CHK("hold byte", {8'h00, ex[7:0]}, d1)
        rd2(8'(8'h32 + 2 * i), d1, d2);
        `CHK("cleared", 16'h0000, d1)
      end
    end
  endtask
  // one-second sums, status bits, and a quiet second
  task t_second;
    pulse(pcb_evt_s'(10'h008), 7);
    pulse(pcb_evt_s'(10'h004), 2);
    pulse(pcb_evt_s'(10'h002), 3);
    pulse(pcb_evt_s'(10'h001), 1);
    rd2(OFS_LCV_HI, d1, d2);
    `CHK("lcv sum", 16'd7, d1)
    `CHK("lcv kept", 16'd7, d2)
    rd2(OFS_PBIT_HI, d1, d2);
    `CHK("pbit sum", 16'd2, d1)
    rd2(OFS_HEC_HI, d1, d2);
    `CHK("hec sum", 16'd3, d1)
    rd2(OFS_SEC_STATUS, d1, d2);
    `CHK("status", 16'h0003, d1)
    rd(OFS_LCV_HI, 1'b0, d1);
    rd(OFS_HOLD, 1'b0, d1);
    `CHK("acc hold", 16'h0007, d1)
    // 20000 payload bits make one violation too few for severe
    bit_tick = 1'b1;
    pulse(pcb_evt_s'(10'h008), 1);
    repeat (20000) @(negedge sys_clk);
    bit_tick = 1'b0;
    pulse(pcb_evt_s'(10'h001), 1);
    rd2(OFS_SEC_STATUS, d1, d2);
    `CHK("errored only", 16'h0002, d1)
    rd2(OFS_LCV_HI, d1, d2);
    `CHK("lcv restart", 16'd1, d1)
    pulse(pcb_evt_s'(10'h001), 1);
    rd2(OFS_SEC_STATUS, d1, d2);
    `CHK("quiet status", 16'h0000, d1)
  endtask
  // clear-channel mode: shared pair counts prbs, cell counters idle
  task t_mode;
    atm_mode = 1'b0;
    pulse(pcb_evt_s'(10'h3f2), 5);
    pulse(pcb_evt_s'(10'h001), 1);
    rd2(OFS_RX_IDLE_HI, d1, d2);
    `CHK("prbs count", 16'd5, d1)
    for (int a = 8'h34; a <= 8'h3a; a += 2) begin
      rd2(8'(a), d1, d2);
      `CHK("idle counter", 16'h0000, d1)
    end
    rd2(OFS_HEC_HI, d1, d2);
    `CHK("hec idle", 16'h0000, d1)
    // narrow pair: low byte comes from the snapshot of the high read
    pulse(pcb_evt_s'(10'h100), 3);
    rd(OFS_RX_IDLE_HI, 1'b0, d1);
    `CHK("prbs high", 16'h0000, d1)
    pulse(pcb_evt_s'(10'h100), 2);
    rd(OFS_RX_IDLE_LO, 1'b0, d1);
    `CHK("pair low", 16'h0003, d1)
    rd2(OFS_RX_IDLE_HI, d1, d2);
    `CHK("kept count", 16'd2, d1)
    atm_mode = 1'b1;
  endtask
  initial begin
    repeat (20) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_reset();
    t_cells();
    t_second();
    t_mode();
    give_verdict();
  end
endmodule
